// File: design/wdt_defs.svh
// offsets, field positions, reset values and timing counts of the watchdog
`ifndef WDT_DEFS_SVH
`define WDT_DEFS_SVH

// ----------------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------------
`define WDT_CTRL_OFFSET 8'h60
`define WDT_RSTSRC_OFFSET 8'h54

// ----------------------------------------------------------------------
// watchdog_control_status fields
// ----------------------------------------------------------------------
`define WDT_CTRL_IRQ_FLAG_BIT 7
`define WDT_CTRL_IRQ_EN_BIT 6
`define WDT_CTRL_PERIOD_HI_BIT 5
`define WDT_CTRL_UNLOCK_BIT 4
`define WDT_CTRL_RESET_EN_BIT 3
`define WDT_CTRL_PERIOD_LO_MSB 2

// ----------------------------------------------------------------------
// reset_source_status fields
// ----------------------------------------------------------------------
`define WDT_RS_TEST_PORT_BIT 4
`define WDT_RS_TIMEOUT_BIT 3
`define WDT_RS_BROWNOUT_BIT 2
`define WDT_RS_PIN_BIT 1
`define WDT_RS_POWER_ON_BIT 0

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define WDT_PERIOD_RESET 4'h0
`define WDT_RSTSRC_POR_VALUE 5'h01

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define WDT_CHANGE_WINDOW_CYCLES 4
`define WDT_BASE_TIMEOUT_CYCLES 2048
`define WDT_PERIOD_MAX_CODE 4'h9
`define WDT_OSC_FREQ_KHZ 128

`endif

// File: design/wdt_pkg.sv
// types shared by the watchdog files
package wdt_pkg;

   // ----------------------------------------------------------------------
   // operating mode, coded as {reset enable, interrupt enable}
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {
      MODE_STOPPED = 2'b00,
      MODE_IRQ = 2'b01,
      MODE_RESET = 2'b10,
      MODE_IRQ_RESET = 2'b11
   } wdt_mode_t;

   typedef logic [3:0] period_code_t;

endpackage

// File: design/wdt_period_counter.sv
// oscillator-cycle counter comparing against the selected time-out
`timescale 1ns/1ps
`default_nettype none
`include "wdt_defs.svh"

module wdt_period_counter #(
   parameter int unsigned BASE_TIMEOUT = `WDT_BASE_TIMEOUT_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic run,
   input wire logic restart,
   input wire logic osc_tick,
   input wire logic [3:0] period_select,
   output logic timeout
);

   localparam int unsigned CW = $clog2(BASE_TIMEOUT * 512) + 1;

   if (BASE_TIMEOUT < 2)
   begin : g_bad_base
      $error("BASE_TIMEOUT must be at least 2");
   end

   // ----------------------------------------------------------------------
   // limit lookup
   // ----------------------------------------------------------------------
   // reserved codes fall back to the longest period, never a short one
   function automatic logic [CW-1:0] limit_of(input logic [3:0] code);
      logic [3:0] c;
      c = (code > `WDT_PERIOD_MAX_CODE) ? `WDT_PERIOD_MAX_CODE : code;
      limit_of = CW'(BASE_TIMEOUT) << c;
   endfunction

   // ----------------------------------------------------------------------
   // counter
   // ----------------------------------------------------------------------
   logic [CW-1:0] count_r;
   logic [CW-1:0] count_nxt;
   logic [CW-1:0] limit;

   always_comb
   begin
      limit = limit_of(period_select);
      timeout = 1'b0;
      count_nxt = count_r;
      if (restart || !run)
         count_nxt = '0;
      else if (osc_tick)
      begin
         // a shorter period picked mid-count ends at the next oscillator tick
         if (count_r >= limit - CW'(1))
         begin
            timeout = 1'b1;
            count_nxt = '0;
         end
         else
            count_nxt = count_r + CW'(1);
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         count_r <= '0;
      else
         count_r <= count_nxt;
   end

endmodule // wdt_period_counter
`default_nettype wire

// File: design/watchdog_with_reset_flags.sv
// watchdog with protected set-up and reset-source flags, APB slave
`timescale 1ns/1ps
`default_nettype none
`include "wdt_defs.svh"

module watchdog_with_reset_flags #(
   parameter int unsigned BASE_TIMEOUT = `WDT_BASE_TIMEOUT_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic osc_tick,
   input wire logic wdt_restart,
   input wire logic always_on_fuse,
   input wire logic global_irq_enable,
   input wire logic irq_ack,
   input wire logic test_port_reset_evt,
   input wire logic pin_reset_evt,
   input wire logic brownout_evt,
   output logic timeout_irq_req,
   output logic timeout_reset_req
);

   localparam int unsigned UNLOCK_CW = $clog2(`WDT_CHANGE_WINDOW_CYCLES) + 1;

   if (`WDT_CHANGE_WINDOW_CYCLES < 1)
   begin : g_bad_window
      $error("change window must be at least one cycle");
   end

   // ----------------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------------
   // a programmed fuse (0) pins the mode to reset
   function automatic wdt_pkg::wdt_mode_t mode_of(input logic fuse, input logic re,
                                                  input logic ie);
      if (!fuse)
         mode_of = wdt_pkg::MODE_RESET;
      else
         mode_of = wdt_pkg::wdt_mode_t'({re, ie});
   endfunction

   // ----------------------------------------------------------------------
   // state
   // ----------------------------------------------------------------------
   logic irq_flag_r, irq_flag_nxt;
   logic irq_en_r, irq_en_nxt;
   logic reset_en_r, reset_en_nxt;
   wdt_pkg::period_code_t period_r, period_nxt;
   logic unlock_r, unlock_nxt;
   logic [UNLOCK_CW-1:0] unlock_cnt_r, unlock_cnt_nxt;
   logic [4:0] rstsrc_r, rstsrc_nxt;
   logic [31:0] prdata_r, prdata_nxt;
   logic pready_r, pready_nxt;
   logic pslverr_r, pslverr_nxt;
   logic irq_req_r, irq_req_nxt;
   logic reset_req_r, reset_req_nxt;

   wdt_pkg::wdt_mode_t mode;
   logic timeout;
   logic wd_reset_now;
   logic irq_set;
   logic sys_evt;
   logic hit_ctrl;
   logic hit_rstsrc;
   logic wr_ctrl;
   logic wr_rstsrc;
   logic [7:0] ctrl_view;

   // ----------------------------------------------------------------------
   // time-out counter
   // ----------------------------------------------------------------------
   wdt_period_counter #(
      .BASE_TIMEOUT(BASE_TIMEOUT)
   ) u_counter (
      .pclk(pclk),
      .presetn(presetn),
      .run(mode != wdt_pkg::MODE_STOPPED),
      // own time-out already zeroes the count; feeding it back would loop
      .restart(wdt_restart | test_port_reset_evt | pin_reset_evt | brownout_evt),
      .osc_tick(osc_tick),
      .period_select(period_r),
      .timeout(timeout)
   );

   // ----------------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------------
   always_comb
   begin
      mode = mode_of(always_on_fuse, reset_en_r, irq_en_r);
      hit_ctrl = (paddr == `WDT_CTRL_OFFSET);
      hit_rstsrc = (paddr == `WDT_RSTSRC_OFFSET);
      wr_ctrl = psel && penable && pready_r && pwrite && hit_ctrl;
      wr_rstsrc = psel && penable && pready_r && pwrite && hit_rstsrc;
      ctrl_view = {irq_flag_r, irq_en_r, period_r[3], unlock_r, reset_en_r, period_r[2:0]};

      // combined mode resets only if the first time-out was never serviced
      wd_reset_now = timeout && ((mode == wdt_pkg::MODE_RESET) ||
                     ((mode == wdt_pkg::MODE_IRQ_RESET) && irq_flag_r));
      irq_set = timeout && ((mode == wdt_pkg::MODE_IRQ) ||
                ((mode == wdt_pkg::MODE_IRQ_RESET) && !irq_flag_r));
      sys_evt = wd_reset_now || test_port_reset_evt || pin_reset_evt || brownout_evt;
   end

   // ----------------------------------------------------------------------
   // change window
   // ----------------------------------------------------------------------
   always_comb
   begin
      unlock_nxt = unlock_r;
      unlock_cnt_nxt = unlock_cnt_r;
      // window runs down on its own, four cycles from the unlocking write
      if (unlock_r)
      begin
         if (unlock_cnt_r == '0)
            unlock_nxt = 1'b0;
         else
            unlock_cnt_nxt = unlock_cnt_r - UNLOCK_CW'(1);
      end
      if (wr_ctrl)
      begin
         if (pwdata[`WDT_CTRL_UNLOCK_BIT])
         begin
            unlock_nxt = 1'b1;
            unlock_cnt_nxt = UNLOCK_CW'(`WDT_CHANGE_WINDOW_CYCLES - 1);
         end
         else
            unlock_nxt = 1'b0;
      end
      if (sys_evt)
      begin
         unlock_nxt = 1'b0;
         unlock_cnt_nxt = '0;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         unlock_r <= 1'b0;
         unlock_cnt_r <= '0;
      end
      else
      begin
         unlock_r <= unlock_nxt;
         unlock_cnt_r <= unlock_cnt_nxt;
      end
   end

   // ----------------------------------------------------------------------
   // control set-up
   // ----------------------------------------------------------------------
   always_comb
   begin
      irq_flag_nxt = irq_flag_r;
      irq_en_nxt = irq_en_r;
      reset_en_nxt = reset_en_r;
      period_nxt = period_r;
      if (wr_ctrl)
      begin
         if (pwdata[`WDT_CTRL_IRQ_FLAG_BIT])
            irq_flag_nxt = 1'b0;
         irq_en_nxt = pwdata[`WDT_CTRL_IRQ_EN_BIT];
         if (pwdata[`WDT_CTRL_RESET_EN_BIT])
            reset_en_nxt = 1'b1;
         else if (unlock_r)
            reset_en_nxt = 1'b0;
         if (unlock_r)
            period_nxt = {pwdata[`WDT_CTRL_PERIOD_HI_BIT],
                          pwdata[`WDT_CTRL_PERIOD_LO_MSB:0]};
      end

      // vector entry; in combined mode it also drops to plain reset mode
      if (irq_ack)
      begin
         irq_flag_nxt = 1'b0;
         if (mode == wdt_pkg::MODE_IRQ_RESET)
            irq_en_nxt = 1'b0;
      end

      // set wins over any clear in the same cycle
      if (irq_set)
         irq_flag_nxt = 1'b1;

      // a system reset reinitialises the set-up and clears the interrupt flag
      if (sys_evt)
      begin
         irq_flag_nxt = 1'b0;
         irq_en_nxt = 1'b0;
         reset_en_nxt = 1'b0;
         period_nxt = `WDT_PERIOD_RESET;
      end

      // keeps a failing system resetting until software clears the flag
      if (rstsrc_nxt[`WDT_RS_TIMEOUT_BIT])
         reset_en_nxt = 1'b1;
      if (!always_on_fuse)
      begin
         reset_en_nxt = 1'b1;
         irq_en_nxt = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         irq_flag_r <= 1'b0;
         irq_en_r <= 1'b0;
         reset_en_r <= 1'b0;
         period_r <= `WDT_PERIOD_RESET;
      end
      else
      begin
         irq_flag_r <= irq_flag_nxt;
         irq_en_r <= irq_en_nxt;
         reset_en_r <= reset_en_nxt;
         period_r <= period_nxt;
      end
   end

   // ----------------------------------------------------------------------
   // reset source flags
   // ----------------------------------------------------------------------
   always_comb
   begin
      rstsrc_nxt = rstsrc_r;
      // a written zero clears, events set and win
      if (wr_rstsrc)
         rstsrc_nxt = rstsrc_r & pwdata[4:0];
      if (test_port_reset_evt)
         rstsrc_nxt[`WDT_RS_TEST_PORT_BIT] = 1'b1;
      if (wd_reset_now)
         rstsrc_nxt[`WDT_RS_TIMEOUT_BIT] = 1'b1;
      if (brownout_evt)
         rstsrc_nxt[`WDT_RS_BROWNOUT_BIT] = 1'b1;
      if (pin_reset_evt)
         rstsrc_nxt[`WDT_RS_PIN_BIT] = 1'b1;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         rstsrc_r <= `WDT_RSTSRC_POR_VALUE;
      else
         rstsrc_r <= rstsrc_nxt;
   end

   // ----------------------------------------------------------------------
   // bus answer and requests
   // ----------------------------------------------------------------------
   always_comb
   begin
      irq_req_nxt = irq_flag_nxt && irq_en_nxt && global_irq_enable;
      reset_req_nxt = wd_reset_now;

      // one wait state: answer in the second access cycle
      pready_nxt = psel && penable && !pready_r;
      pslverr_nxt = pready_nxt && !(hit_ctrl || hit_rstsrc);
      prdata_nxt = prdata_r;
      if (pready_nxt)
      begin
         if (hit_ctrl)
            prdata_nxt = {24'h000000, ctrl_view};
         else if (hit_rstsrc)
            prdata_nxt = {27'h0000000, rstsrc_r};
         else
            prdata_nxt = 32'h00000000;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata_r <= 32'h00000000;
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         irq_req_r <= 1'b0;
         reset_req_r <= 1'b0;
      end
      else
      begin
         prdata_r <= prdata_nxt;
         pready_r <= pready_nxt;
         pslverr_r <= pslverr_nxt;
         irq_req_r <= irq_req_nxt;
         reset_req_r <= reset_req_nxt;
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign timeout_irq_req = irq_req_r;
   assign timeout_reset_req = reset_req_r;

endmodule // watchdog_with_reset_flags
`default_nettype wire

// File: verification/watchdog_with_reset_flags_chk.sv
// port-level checker for the watchdog block
`timescale 1ns/1ps
`default_nettype none
`include "wdt_defs.svh"

module watchdog_with_reset_flags_chk #(
   parameter int unsigned BASE_TIMEOUT = 4
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic osc_tick,
   input wire logic wdt_restart,
   input wire logic always_on_fuse,
   input wire logic global_irq_enable,
   input wire logic irq_ack,
   input wire logic test_port_reset_evt,
   input wire logic pin_reset_evt,
   input wire logic brownout_evt,
   input wire logic timeout_irq_req,
   input wire logic timeout_reset_req
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // -----------------------------------------
   // properties
   // -----------------------------------------
   a_one_wait_state:
      assert property ($rose(psel && penable) |-> !pready ##1 pready)
      else $error("pready not after one wait state");
   a_ready_single:
      assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   a_err_decode:
      assert property (pready |-> pslverr == !(paddr == `WDT_CTRL_OFFSET
         || paddr == `WDT_RSTSRC_OFFSET))
      else $error("pslverr does not match address decode");
   a_read_unused_zero:
      assert property (pready && !pwrite |-> prdata[31:8] == 24'h0
         && (paddr != `WDT_RSTSRC_OFFSET || prdata[7:5] == 3'h0)
         && (!pslverr || prdata == 32'h0))
      else $error("unused read bits not zero");
   a_irq_needs_global:
      assert property (timeout_irq_req |-> $past(global_irq_enable))
      else $error("irq request without global enable");
   a_irq_masked:
      assert property (!global_irq_enable |=> !timeout_irq_req)
      else $error("irq request while masked");
   a_fuse_no_irq:
      assert property (!always_on_fuse ##1 !always_on_fuse |=> !timeout_irq_req)
      else $error("irq request with fuse programmed");
   a_reset_req_pulse:
      assert property (timeout_reset_req |=> !timeout_reset_req)
      else $error("reset request longer than one cycle");
   a_reset_after_tick:
      assert property ($rose(timeout_reset_req) |-> $past(osc_tick)
         || $past(osc_tick, 2) || $past(osc_tick, 3))
      else $error("reset request without oscillator tick");
endmodule // watchdog_with_reset_flags_chk

bind watchdog_with_reset_flags watchdog_with_reset_flags_chk #(
   .BASE_TIMEOUT(BASE_TIMEOUT)
) chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
   .pready, .pslverr, .osc_tick, .wdt_restart, .always_on_fuse,
   .global_irq_enable, .irq_ack, .test_port_reset_evt, .pin_reset_evt,
   .brownout_evt, .timeout_irq_req, .timeout_reset_req);

`default_nettype wire

// File: verification/watchdog_with_reset_flags_test.sv
// self-checking bench for the watchdog block
`timescale 1ns/1ps
`default_nettype none
`include "wdt_defs.svh"

module watchdog_with_reset_flags_test;
   localparam logic [7:0] CT = `WDT_CTRL_OFFSET;
   localparam logic [7:0] RS = `WDT_RSTSRC_OFFSET;
   typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic e;} row_t;
   logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
   logic pwrite = 1'h0, pready, pslverr, erv, timeout_irq_req, timeout_reset_req;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rdv;
   logic osc_tick = 1'h0, wdt_restart = 1'h0, always_on_fuse = 1'h1;
   logic global_irq_enable = 1'h0, irq_ack = 1'h0, test_port_reset_evt = 1'h0;
   logic pin_reset_evt = 1'h0, brownout_evt = 1'h0;
   int n_errors = 0, n_checks = 0;
   // reads carry the expected data in d
   row_t rows [11] = '{'{1'h0, CT, 32'h00, 1'h0}, '{1'h0, RS, 32'h01, 1'h0},
      '{1'h0, 8'h40, 32'h00, 1'h1}, '{1'h1, 8'h40, 32'hff, 1'h1},
      '{1'h1, CT, 32'h67, 1'h0}, '{1'h0, CT, 32'h40, 1'h0},
      '{1'h1, CT, 32'h18, 1'h0}, '{1'h1, CT, 32'h01, 1'h0},
      '{1'h0, CT, 32'h01, 1'h0}, '{1'h1, RS, 32'h00, 1'h0},
      '{1'h0, RS, 32'h00, 1'h0}};

   watchdog_with_reset_flags #(.BASE_TIMEOUT(4)) DUT (.pclk, .presetn, .psel,
      .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .osc_tick,
      .wdt_restart, .always_on_fuse, .global_irq_enable, .irq_ack,
      .test_port_reset_evt, .pin_reset_evt, .brownout_evt, .timeout_irq_req,
      .timeout_reset_req);

   always #50 pclk = ~pclk;

   // -----------------------------------------
   // tasks
   // -----------------------------------------
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e)
      begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask

   // idle edge at the end keeps psel from being set twice in one step
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic er);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do @(posedge pclk); while (pready !== 1'h1);
      r = prdata;
      er = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge pclk);
   endtask

   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'h1, a, d, rdv, erv);
   endtask

   task rd(input logic [7:0] a, input logic [31:0] e);
      apb(1'h0, a, 32'h0, rdv, erv);
      chk("prdata", e, rdv);
   endtask

   // 0 restart, 1 test port, 2 pin, 3 brown-out, 4 vector ack
   task pulse(input int i);
      {irq_ack, brownout_evt, pin_reset_evt, test_port_reset_evt, wdt_restart}
         <= 5'h1 << i;
      @(posedge pclk);
      {irq_ack, brownout_evt, pin_reset_evt, test_port_reset_evt, wdt_restart}
         <= 5'h0;
      @(posedge pclk);
   endtask

   // ticks spaced so a request is tied to the tick that caused it
   task ticks(input int en, input logic [1:0] ek);
      int n;
      logic [1:0] k;
      n = 0;
      k = 2'h0;
      while (k == 2'h0 && n < 40)
      begin
         osc_tick <= 1'h1;
         @(posedge pclk);
         osc_tick <= 1'h0;
         n++;
         repeat (4)
         begin
            @(posedge pclk);
            if (timeout_reset_req === 1'h1) k = 2'h2;
            else if (k == 2'h0 && timeout_irq_req === 1'h1) k = 2'h1;
         end
      end
      chk("ticks", en, n);
      chk("kind", ek, k);
   endtask

   task wrap_up;
      if (n_errors == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   initial
   begin
      #500000;
      n_errors++;
      wrap_up;
   end

   initial
   begin
      logic [31:0] e;
      repeat (5) @(posedge pclk);
      presetn <= 1'h1;
      @(posedge pclk);
      pulse(0);
      foreach (rows[i])
      begin
         apb(rows[i].w, rows[i].a, rows[i].d, rdv, erv);
         chk("pslverr", rows[i].e, erv);
         if (!rows[i].w) chk("prdata", rows[i].d, rdv);
      end
      wr(CT, 32'h18);
      repeat (5) @(posedge pclk);
      wr(CT, 32'h02);
      rd(CT, 32'h09);
      pulse(0);
      ticks(8, 2'h2);
      rd(RS, 32'h08);
      wr(CT, 32'h18);
      wr(CT, 32'h00);
      rd(CT, 32'h08);
      wr(RS, 32'h00);
      wr(CT, 32'h18);
      wr(CT, 32'h00);
      rd(CT, 32'h00);
      global_irq_enable <= 1'h1;
      wr(CT, 32'h40);
      pulse(0);
      ticks(4, 2'h1);
      rd(CT, 32'hc0);
      global_irq_enable <= 1'h0;
      repeat (2) @(posedge pclk);
      chk("irq_req", 1'h0, timeout_irq_req);
      global_irq_enable <= 1'h1;
      wr(CT, 32'hc0);
      rd(CT, 32'h40);
      wr(CT, 32'h48);
      pulse(0);
      ticks(4, 2'h1);
      pulse(4);
      rd(CT, 32'h08);
      pulse(0);
      ticks(4, 2'h2);
      // unserviced first time-out: the second one must reset
      wr(CT, 32'h48);
      pulse(0);
      ticks(4, 2'h1);
      global_irq_enable <= 1'h0;
      ticks(4, 2'h2);
      wr(RS, 32'h00);
      e = 32'h0;
      for (int i = 1; i < 4; i++)
      begin
         pulse(i);
         e = e | ((i == 1) ? 32'h10 : 32'h1 << (i - 1));
         rd(RS, e);
      end
      always_on_fuse <= 1'h0;
      wr(CT, 32'h40);
      rd(CT, 32'h08);
      pulse(0);
      ticks(4, 2'h2);
      always_on_fuse <= 1'h1;
      presetn <= 1'h0;
      repeat (2) @(posedge pclk);
      presetn <= 1'h1;
      @(posedge pclk);
      rd(RS, 32'h01);
      wrap_up;
   end
endmodule // watchdog_with_reset_flags_test

`default_nettype wire
